// ### dspma_bf16_fma.sv
`timescale 1ns/1ps
module dspma_bf16_fma
    import dspma_pkg::*;
(
    input  wire logic [15:0] op_a,
    input  wire logic [15:0] op_b,
    input  wire logic [15:0] op_c,
    output logic      [15:0] sum
);

    logic               sp;
    logic               sr;
    logic               pz;
    logic               cz;
    logic        [15:0] pm;
    logic        [33:0] mp;
    logic        [33:0] mc;
    logic        [33:0] mr;
    logic signed [10:0] ep;
    logic signed [10:0] ec;
    logic signed [10:0] big;
    logic signed [10:0] diff;
    logic signed [10:0] re;
    logic        [5:0]  lead;
    logic        [33:0] mant;

    // product kept exact, one rounding step only at the end (truncation)
    always_comb begin
        sp   = op_a[15] ^ op_b[15];
        pz   = (op_a[14:7] == 8'h00) || (op_b[14:7] == 8'h00);
        cz   = (op_c[14:7] == 8'h00);
        pm   = 16'({1'b1, op_a[6:0]} * {1'b1, op_b[6:0]});
        ep   = $signed({3'h0, op_a[14:7]}) + $signed({3'h0, op_b[14:7]}) - BF_BIAS;
        ec   = $signed({3'h0, op_c[14:7]});
        mp   = pz ? 34'h0 : (34'(pm) << 16);      // binary point at bit 30
        mc   = cz ? 34'h0 : (34'({1'b1, op_c[6:0]}) << 23);
        big  = ep;
        diff = 11'sh000;
        if (pz || (!cz && ec > ep)) begin
            big  = ec;
            diff = ec - ep;
            mp   = (diff > BF_SH_MAX) ? 34'h0 : (mp >> diff);
        end else begin
            diff = ep - ec;
            mc   = (diff > BF_SH_MAX) ? 34'h0 : (mc >> diff);
        end
        // fused add on aligned magnitudes
        sr = sp;
        if (sp == op_c[15]) begin
            mr = mp + mc;
        end else if (mp >= mc) begin
            mr = mp - mc;
        end else begin
            mr = mc - mp;
            sr = op_c[15];
        end
        lead = 6'h00;
        for (int i = 0; i < 34; i++) begin
            if (mr[i]) begin
                lead = 6'(i);
            end
        end
        re   = big + $signed({5'h00, lead}) - BF_POINT;
        mant = (lead >= 6'h07) ? (mr >> (lead - 6'h07)) : (mr << (6'h07 - lead));
        // denormals flush to zero, overflow saturates to infinity
        if (mr == 34'h0 || re <= 11'sh000) begin
            sum = {sr, 15'h0000};
        end else if (re >= BF_EXP_MAX) begin
            sum = {sr, 8'hFF, 7'h00};
        end else begin
            sum = {sr, re[7:0], mant[6:0]};
        end
    end

endmodule

// ### dspma_block.sv
`timescale 1ns/1ps
module dspma_block
    import dspma_pkg::*;
(
    input  wire logic           SYS_CLK,
    input  wire logic           RST_N,
    input  wire logic           WB_CYC,
    input  wire logic           WB_STB,
    input  wire logic           WB_WE,
    input  wire logic [7:0]     WB_ADR,
    input  wire logic [3:0]     WB_SEL,
    input  wire logic [31:0]    WB_DAT_W,
    output logic      [31:0]    WB_DAT_R,
    output logic                WB_ACK,
    input  wire dspma_opnd_type OPND,
    input  wire logic           OPND_VALID,
    output logic      [47:0]    RESULT,
    output logic                RESULT_VALID
);

    // bus group
    logic                ack_r;
    logic                ack_nxt;
    logic [31:0]         rdata_r;
    logic [31:0]         rdata_nxt;
    dspma_cfg_type       cfg_r;
    dspma_cfg_type       cfg_nxt;
    logic                hit;
    logic                wr;
    logic                acc_clr;
    logic [LANES-1:0]    ovf_clr;

    // datapath group
    dspma_opnd_type      opnd_r;
    dspma_opnd_type      opnd_nxt;
    logic                vld_r;
    logic                vld_nxt;
    logic [RES_W-1:0]    res_r;
    logic [RES_W-1:0]    res_nxt;
    logic                ovld_r;
    logic                ovld_nxt;
    logic [LANES-1:0]    ovf_r;
    logic [LANES-1:0]    ovf_nxt;
    logic [31:0]         cnt_r;
    logic [31:0]         cnt_nxt;
    logic [RES_W-1:0]    calc;
    logic [LANES-1:0]    calc_ovf;
    logic [15:0]         fl_c;
    logic [15:0]         fl_sum;

    // sign or zero extend the low w bits of v to the full width
    function automatic logic [47:0] fit(input logic [47:0] v, input int w, input logic sgn);
        logic [47:0] t;
        t = v << (48 - w);
        if (sgn) begin
            fit = 48'($signed(t) >>> (48 - w));
        end else begin
            fit = t >> (48 - w);
        end
    endfunction

    // one integer lane: multiply, add stage, wrap to lane width, shift, place
    // returns {overflow, placed result}
    function automatic logic [48:0] lane_calc(
        input dspma_lane_type ln,
        input dspma_opnd_type o,
        input logic [47:0]    prev,
        input dspma_op_type   op,
        input logic [3:0]     sh,
        input logic           sgn
    );
        logic [47:0] pa;
        logic [47:0] pb;
        logic [47:0] prod;
        logic [47:0] add;
        logic [47:0] full;
        logic [47:0] s;
        logic        ovf;
        int          rw;
        rw   = int'(ln.rw);
        pa   = fit(48'(o.a) >> ln.aoff, int'(ln.aw), sgn);
        pb   = fit(48'(o.b) >> ln.boff, int'(ln.bw), sgn);
        // the 7x6 quad product is 13 bits and loses its top bit here
        prod = fit(48'(pa * pb), rw, sgn);
        add  = fit(o.c >> ln.roff, rw, sgn);
        unique case (op)
            OP_ADD: full = prod + add;
            OP_SUB: full = prod - add;
            OP_ACC: full = prod + fit(prev >> ln.roff, rw, sgn);
            OP_MUL: full = prod;
        endcase
        s   = fit(full, rw, sgn);
        ovf = (op != OP_MUL) && (s != full) && (rw < 48);
        if (sgn) begin
            s = 48'($signed(s) >>> sh);
        end else begin
            s = s >> sh;
        end
        lane_calc = {ovf, fit(s, rw, 1'b0) << ln.roff};
    endfunction

    // ---------------------------------------------------------------------
    // wishbone slave: ack one cycle after the strobe, dropped the next cycle
    // ---------------------------------------------------------------------
    always_comb begin
        hit       = WB_CYC && WB_STB && !ack_r;
        wr        = hit && WB_WE;
        ack_nxt   = hit;
        cfg_nxt   = cfg_r;
        rdata_nxt = rdata_r;
        acc_clr   = 1'b0;
        ovf_clr   = '0;
        if (wr && WB_ADR == REG_CTRL) begin
            if (WB_SEL[0]) begin
                cfg_nxt.mode = dspma_mode_type'(WB_DAT_W[CTRL_MODE_LSB +: 2]);
                cfg_nxt.sgn  = WB_DAT_W[CTRL_SGN_BIT];
                cfg_nxt.op   = dspma_op_type'(WB_DAT_W[CTRL_OP_LSB +: 2]);
            end
            acc_clr = WB_SEL[1] && WB_DAT_W[CTRL_CLR_BIT];
        end
        if (wr && WB_ADR == REG_SHIFT) begin
            if (WB_SEL[0]) begin
                cfg_nxt.shift[7:0] = WB_DAT_W[7:0];
            end
            if (WB_SEL[1]) begin
                cfg_nxt.shift[15:8] = WB_DAT_W[15:8];
            end
        end
        if (wr && WB_ADR == REG_STATUS && WB_SEL[0]) begin
            ovf_clr = WB_DAT_W[LANES-1:0];                           // write one to clear
        end
        if (hit && !WB_WE) begin
            unique case (WB_ADR)
                REG_CTRL:   rdata_nxt = {27'h0, cfg_r.op, cfg_r.sgn, cfg_r.mode};
                REG_SHIFT:  rdata_nxt = {16'h0000, cfg_r.shift};
                REG_RES_LO: rdata_nxt = res_r[31:0];
                REG_RES_HI: rdata_nxt = {16'h0000, res_r[47:32]};
                REG_STATUS: rdata_nxt = {28'h0, ovf_r};
                REG_COUNT:  rdata_nxt = cnt_r;
                default:    rdata_nxt = 32'h0000_0000;               // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
            cfg_r   <= CFG_RST;
        end else begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
            cfg_r   <= cfg_nxt;
        end
    end

    assign WB_ACK   = ack_r;
    assign WB_DAT_R = rdata_r;

    // ---------------------------------------------------------------------
    // float lane: addend picked by operation, negated for subtract
    // ---------------------------------------------------------------------
    always_comb begin
        unique case (cfg_r.op)
            OP_ADD: fl_c = opnd_r.c[15:0];
            OP_SUB: fl_c = {~opnd_r.c[15], opnd_r.c[14:0]};
            OP_ACC: fl_c = res_r[15:0];
            OP_MUL: fl_c = 16'h0000;
        endcase
    end

    dspma_bf16_fma u_fma (
        .op_a (opnd_r.a[15:0]),
        .op_b (opnd_r.b[15:0]),
        .op_c (fl_c),
        .sum  (fl_sum)
    );

    // ---------------------------------------------------------------------
    // lane evaluation: table walk so the normal, dual and quad modes share one lane datapath
    // ---------------------------------------------------------------------
    always_comb begin
        logic [48:0] l;
        l        = '0;
        calc     = '0;
        calc_ovf = '0;
        if (cfg_r.mode == MODE_FLOAT) begin
            calc = {32'h0000_0000, fl_sum};
        end else begin
            for (int i = 0; i < LANES; i++) begin
                if (3'(i) < LANE_CNT[cfg_r.mode]) begin
                    // normal dual quad
                    l = lane_calc(LANE_TAB[cfg_r.mode][i], opnd_r, res_r, cfg_r.op,
                                  cfg_r.shift[i*SH_W +: SH_W], cfg_r.sgn);
                    calc        = calc | l[47:0];
                    calc_ovf[i] = l[48];
                end
            end
        end
    end

    // ---------------------------------------------------------------------
    // pipeline: operands registered, then result registered one edge later
    // ---------------------------------------------------------------------
    always_comb begin
        opnd_nxt = OPND;
        vld_nxt  = OPND_VALID;
        res_nxt  = res_r;
        ovld_nxt = 1'b0;
        cnt_nxt  = cnt_r;
        // a new overflow in the clearing cycle survives the clear
        ovf_nxt  = ovf_r & ~ovf_clr;
        if (vld_r) begin
            res_nxt  = calc;
            ovld_nxt = 1'b1;
            cnt_nxt  = cnt_r + 32'h0000_0001;
            ovf_nxt  = ovf_nxt | calc_ovf;
        end
        // software clear beats a result landing in the same cycle
        if (acc_clr) begin
            res_nxt = '0;
            cnt_nxt = 32'h0000_0000;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            opnd_r <= '0;
            vld_r  <= 1'b0;
            res_r  <= '0;
            ovld_r <= 1'b0;
            ovf_r  <= '0;
            cnt_r  <= 32'h0000_0000;
        end else begin
            opnd_r <= opnd_nxt;
            vld_r  <= vld_nxt;
            res_r  <= res_nxt;
            ovld_r <= ovld_nxt;
            ovf_r  <= ovf_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    assign RESULT       = res_r;
    assign RESULT_VALID = ovld_r;

endmodule

// ### dspma_block_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module dspma_block_bench
    import dspma_pkg::*;
;
    logic           sys_clk;
    logic           rst_n    = 1'b0;
    logic           wb_cyc   = 1'b0;
    logic           wb_stb   = 1'b0;
    logic           wb_we    = 1'b0;
    logic [7:0]     wb_adr   = 8'h00;
    logic [3:0]     wb_sel   = 4'h0;
    logic [31:0]    wb_dat_w = 32'h0;
    logic [31:0]    wb_dat_r;
    logic           wb_ack;
    dspma_opnd_type opnd;
    logic           opnd_valid;
    logic [47:0]    result;
    logic           result_valid;
    logic [47:0]    got;
    logic [15:0]    n_got;
    logic [31:0]    q;
    logic [47:0]    r;
    logic [3:0]     wsel     = 4'hF;
    int             n_errors = 0;
    int             tests_run = 0;

    dspma_block dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .WB_CYC(wb_cyc), .WB_STB(wb_stb),
        .WB_WE(wb_we), .WB_ADR(wb_adr), .WB_SEL(wb_sel), .WB_DAT_W(wb_dat_w),
        .WB_DAT_R(wb_dat_r), .WB_ACK(wb_ack), .OPND(opnd), .OPND_VALID(opnd_valid),
        .RESULT(result), .RESULT_VALID(result_valid));
    dspma_fabric_model fab (.clk(sys_clk), .result(result), .result_valid(result_valid),
        .opnd(opnd), .opnd_valid(opnd_valid), .got(got), .n_got(n_got));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // one classic cycle; the ack edge is the only place data is taken
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] o);
        int k;
        @(posedge sys_clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} <= {2'b11, w, a, wsel, d};
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (wb_ack !== 1'b1 && k < 50);
        // a lost ack is a mismatch, not a silent pass
        if (wb_ack !== 1'b1) n_errors++;
        o = wb_dat_r;
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
    endtask

    task wait_got(input logic [15:0] n);
        int k;
        for (k = 0; k < 20 && n_got != n; k++) @(posedge sys_clk);
        // a missing result pulse counts as a mismatch
        if (n_got !== n) n_errors++;
    endtask

    task run(input logic [31:0] c, input logic [15:0] s, input dspma_opnd_type o,
             output logic [47:0] res);
        logic [15:0] n0;
        wb(1'b1, REG_CTRL, c, q);
        wb(1'b1, REG_SHIFT, {16'h0, s}, q);
        n0 = n_got;
        fab.send(o, 1'b1);
        wait_got(n0 + 16'h1);
        res = got;
    endtask

    function automatic dspma_opnd_type mk(logic [18:0] a, logic [17:0] b, logic [47:0] c);
        return '{a, b, c};
    endfunction

    task t_reset;
        wb(1'b0, REG_CTRL, 32'h0, q);
        `CHK(q, 32'h0);
        `CHK(result, 48'h0);
        wb(1'b0, 8'h1C, 32'h0, q);
        `CHK(q, 32'h0);
    endtask

    task t_normal;
        run(32'h18, 16'h0, mk(19'h7FFFF, 18'h3FFFF, 48'h0), r);
        `CHK(r, 48'h7FFFF * 48'h3FFFF);
        run(32'h18, 16'h0, mk(19'h3, 18'h5, 48'h7), r);
        `CHK(r, 48'hF);
        run(32'h1C, 16'h0, mk(19'h7FFFF, 18'h3, 48'h0), r);
        `CHK(r, 48'hFFFF_FFFF_FFFD);
        run(32'h00, 16'h0, mk(19'h10, 18'h10, 48'h5), r);
        `CHK(r, 48'h105);
        run(32'h08, 16'h0, mk(19'h10, 18'h10, 48'h105), r);
        `CHK(r, 48'hFFFF_FFFF_FFFB);
    endtask

    // two chained accumulates right behind a clear
    task t_acc;
        logic [15:0] n0;
        wb(1'b1, REG_CTRL, 32'h110, q);
        n0 = n_got;
        fab.send(mk(19'h3, 18'h5, 48'h0), 1'b0);
        fab.send(mk(19'h7, 18'h2, 48'h0), 1'b1);
        wait_got(n0 + 16'h2);
        `CHK(got, 48'h1D);
        wb(1'b0, REG_COUNT, 32'h0, q);
        `CHK(q, 32'h2);
    endtask

    task t_lanes;
        run(32'h19, 16'h0, mk({8'hFF, 11'h7FF}, {8'hFF, 10'h3FF}, 48'h0), r);
        `CHK(r, {24'h00FE01, 24'h1FF401});
        run(32'h01, 16'h0, mk({8'h1, 11'h1}, {8'h1, 10'h1}, {24'h1, 24'hFFFFFF}), r);
        `CHK(r, {24'h2, 24'h0});
        run(32'h1D, 16'h0, mk({8'hFF, 11'h7FF}, {8'h2, 10'h2}, 48'h0), r);
        `CHK(r, {24'hFFFFFE, 24'hFFFFFE});
        run(32'h1A, 16'h0, mk(19'h7FFFF, 18'h3FFFF, 48'h0), r);
        `CHK(r, {12'h0E1, 12'h0E1, 12'h0E1, 12'hF41});
    endtask

    task t_shift;
        run(32'h1A, 16'h4321, mk(19'h7FFFF, 18'h3FFFF, 48'h0), r);
        `CHK(r, {12'h00E, 12'h01C, 12'h038, 12'h7A0});
        run(32'h19, 16'h0021, mk({8'h10, 11'h10}, {8'h4, 10'h4}, 48'h0), r);
        `CHK(r, {24'h10, 24'h20});
        run(32'h1C, 16'h000F, mk(19'h7FFF0, 18'h10, 48'h0), r);
        `CHK(r, 48'hFFFF_FFFF_FFFF);
    endtask

    // 1.0 * 2.0 plus or minus 1.0
    task t_float;
        run(32'h03, 16'h0, mk(19'h3F80, 18'h4000, 48'h3F80), r);
        `CHK(r, 48'h4040);
        run(32'h0B, 16'h0, mk(19'h3F80, 18'h4000, 48'h3F80), r);
        `CHK(r, 48'h3F80);
    endtask

    // result registers are read-only; a clear empties the result
    task t_bus;
        wb(1'b1, REG_RES_LO, 32'hFFFF_FFFF, q);
        wb(1'b0, REG_RES_LO, 32'h0, q);
        `CHK(q, 32'h3F80);
        // unmapped read right after a nonzero one must bring zero
        wb(1'b0, 8'h1C, 32'h0, q);
        `CHK(q, 32'h0);
        wb(1'b0, REG_RES_HI, 32'h0, q);
        `CHK(q, 32'h0);
        wb(1'b1, REG_CTRL, 32'h100, q);
        `CHK(result, 48'h0);
    endtask

    // sticky lane overflow, write one to clear, and byte-lane selects
    task t_status;
        wb(1'b1, REG_STATUS, 32'hF, q);
        wb(1'b0, REG_STATUS, 32'h0, q);
        `CHK(q, 32'h0);
        run(32'h09, 16'h0, mk({8'h3, 11'h5}, {8'h3, 10'h3}, {24'h4, 24'h10}), r);
        `CHK(r, {24'h5, 24'hFF_FFFF});
        wb(1'b0, REG_STATUS, 32'h0, q);
        `CHK(q, 32'h1);
        wb(1'b1, REG_STATUS, 32'h1, q);
        wb(1'b0, REG_STATUS, 32'h0, q);
        `CHK(q, 32'h0);
        wsel = 4'h1;
        wb(1'b1, REG_SHIFT, 32'h0000_ABCD, q);
        wsel = 4'hF;
        wb(1'b0, REG_SHIFT, 32'h0, q);
        `CHK(q, 32'h0000_00CD);
    endtask

    // signed quad add, then float accumulate chained on the quad result, whose low 16 bits flush to zero
    task t_more;
        run(32'h06, 16'h0, mk(19'h7FFFF, 18'h3FFFF, {12'hFFF, 12'hFFF, 12'hFFF, 12'h001}), r);
        `CHK(r, {12'h000, 12'h000, 12'h000, 12'h002});
        run(32'h13, 16'h0, mk(19'h3F80, 18'h4000, 48'h0), r);
        `CHK(r, 48'h4000);
        run(32'h13, 16'h0, mk(19'h3F80, 18'h4000, 48'h0), r);
        `CHK(r, 48'h4080);
    endtask

    // reset in mid-run clears result, settings and count
    task t_rst2;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        `CHK(result, 48'h0);
        wb(1'b0, REG_CTRL, 32'h0, q);
        `CHK(q, 32'h0);
        wb(1'b0, REG_COUNT, 32'h0, q);
        `CHK(q, 32'h0);
    endtask

    task close_out;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_normal();
        t_acc();
        t_lanes();
        t_shift();
        t_float();
        t_bus();
        t_status();
        t_more();
        t_rst2();
        close_out();
    end

    // whole run is a few hundred cycles; this only cuts a hang
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        close_out();
    end
endmodule

bind dspma_block dspma_monitor mon (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_CYC(WB_CYC),
    .WB_STB(WB_STB), .WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_DAT_R(WB_DAT_R), .WB_ACK(WB_ACK),
    .OPND_VALID(OPND_VALID), .RESULT(RESULT), .RESULT_VALID(RESULT_VALID));

// ### dspma_fabric_model.sv
`timescale 1ns/1ps
// fabric side: presents operands for one edge each, collects results
module dspma_fabric_model
    import dspma_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [47:0] result,
    input  wire logic        result_valid,
    output dspma_opnd_type   opnd,
    output logic             opnd_valid,
    output logic [47:0]      got,
    output logic [15:0]      n_got
);
    initial begin
        opnd = '0;
        opnd_valid = 1'b0;
        got = 48'h0;
        n_got = 16'h0;
    end

    // last==0 keeps valid up so the next send chains back to back
    task send(input dspma_opnd_type o, input bit last);
        @(posedge clk);
        opnd <= o;
        opnd_valid <= 1'b1;
        if (last) begin
            @(posedge clk);
            opnd_valid <= 1'b0;
            opnd <= ~o; // stale operands are not left looking valid
        end
    endtask

    // result is only seen in its one-cycle pulse
    always @(posedge clk) begin
        if (result_valid) begin
            got <= result;
            n_got <= n_got + 16'h1;
        end
    end
endmodule

// ### dspma_monitor.sv
`timescale 1ns/1ps
// watches only the top ports; result and bus timing relations
module dspma_monitor
    import dspma_pkg::*;
(
    input wire logic        SYS_CLK,
    input wire logic        RST_N,
    input wire logic        WB_CYC,
    input wire logic        WB_STB,
    input wire logic        WB_WE,
    input wire logic [7:0]  WB_ADR,
    input wire logic [31:0] WB_DAT_R,
    input wire logic        WB_ACK,
    input wire logic        OPND_VALID,
    input wire logic [47:0] RESULT,
    input wire logic        RESULT_VALID
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    // operand edge to result pulse is exactly two edges
    AST_RES_LAT: assert property (OPND_VALID |-> ##2 RESULT_VALID)
        else $error("result pulse missing two edges after operands");
    AST_RES_CAUSE: assert property (RESULT_VALID |-> $past(OPND_VALID, 2))
        else $error("result pulse without operands");
    // a clear comes only through a control write, so anything else must hold
    AST_RES_HOLD: assert property ($changed(RESULT) |-> RESULT_VALID
        || $past(WB_CYC && WB_STB && WB_WE && WB_ADR == REG_CTRL))
        else $error("result moved without a valid pulse");
    AST_ACK_LAT: assert property (WB_CYC && WB_STB && !WB_ACK |=> WB_ACK)
        else $error("bus ack not one cycle after request");
    AST_ACK_PULSE: assert property (WB_ACK |=> !WB_ACK)
        else $error("bus ack longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(WB_ACK) |-> $past(WB_CYC && WB_STB))
        else $error("bus ack without request");
    AST_DAT_HOLD: assert property ($changed(WB_DAT_R) |-> WB_ACK && !$past(WB_WE))
        else $error("read data moved outside a read ack");
    AST_RST_CLR: assert property (disable iff (1'b0) !RST_N |=> RESULT == 48'h0
        && !RESULT_VALID && !WB_ACK && WB_DAT_R == 32'h0)
        else $error("reset did not clear outputs");
endmodule

// ### dspma_pkg.sv
package dspma_pkg;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_DUAL, MODE_QUAD, MODE_FLOAT} dspma_mode_type;
    typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_ACC, OP_MUL} dspma_op_type;

    typedef struct packed {
        dspma_mode_type mode;
        logic           sgn;
        dspma_op_type   op;
        logic [15:0]    shift;
    } dspma_cfg_type;

    typedef struct packed {
        logic [18:0] a;
        logic [17:0] b;
        logic [47:0] c;
    } dspma_opnd_type;

    // one multiplier lane: operand offsets and widths, result offset and width
    typedef struct packed {
        logic [5:0] aoff;
        logic [5:0] aw;
        logic [5:0] boff;
        logic [5:0] bw;
        logic [5:0] roff;
        logic [5:0] rw;
    } dspma_lane_type;

    localparam int RES_W = 48;
    localparam int LANES = 4;
    localparam int SH_W  = 4;

    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_SHIFT  = 8'h04;
    localparam logic [7:0] REG_RES_LO = 8'h08;
    localparam logic [7:0] REG_RES_HI = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_COUNT  = 8'h14;

    // control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SGN_BIT  = 2;
    localparam int CTRL_OP_LSB   = 3;
    localparam int CTRL_CLR_BIT  = 8;

    localparam dspma_cfg_type CFG_RST = '{MODE_NORMAL, 1'b0, OP_ADD, 16'h0000};

    localparam dspma_lane_type LANE_NONE = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00};
    localparam logic [2:0] LANE_CNT [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    localparam dspma_lane_type LANE_TAB [4][4] = '{
        '{'{6'h00, 6'h13, 6'h00, 6'h12, 6'h00, 6'h30}, LANE_NONE, LANE_NONE, LANE_NONE},
        '{'{6'h00, 6'h0B, 6'h00, 6'h0A, 6'h00, 6'h18},
          '{6'h0B, 6'h08, 6'h0A, 6'h08, 6'h18, 6'h18}, LANE_NONE, LANE_NONE},
        '{'{6'h00, 6'h07, 6'h00, 6'h06, 6'h00, 6'h0C},
          '{6'h07, 6'h04, 6'h06, 6'h04, 6'h0C, 6'h0C},
          '{6'h0B, 6'h04, 6'h0A, 6'h04, 6'h18, 6'h0C},
          '{6'h0F, 6'h04, 6'h0E, 6'h04, 6'h24, 6'h0C}},
        '{LANE_NONE, LANE_NONE, LANE_NONE, LANE_NONE}
    };

    // brain-float 16 constants
    localparam logic signed [10:0] BF_BIAS    = 11'sh07F;
    localparam logic signed [10:0] BF_POINT   = 11'sh01E;
    localparam logic signed [10:0] BF_EXP_MAX = 11'sh0FF;
    localparam logic signed [10:0] BF_SH_MAX  = 11'sh021;

endpackage
